// *** ca_pkg.sv ***
/*
 * Constants and carrier types for the command/address/clock-enable input stage.
 * Assumes a single 250 MHz clock standing for the rising edge of the differential clock pair.
 */
//
// Contract
// R1 - Row on activate, column on read/write
// R2 - Address bit ten requests auto precharge
// R3 - Precharge one bank or all by bit ten
// R4 - Load mode takes address as op-code
// R5 - Bit twelve picks eight or four beats
// R6 - Bank select picks target bank
// R7 - Bank select picks mode register zero-three
// R8 - Sample inputs on rising clock edge
// R9 - Registered clock enable gates internal circuitry
// R10 - Clock enable low enters power-down or refresh
// R11 - Self-refresh exit detected without clock; here the exit waits for a clock edge with cke high
// R12 - Power-down keeps only clock, enable, reset, termination
// R13 - Self refresh keeps only enable and reset
// R14 - Termination strobe ball selectable on byte-wide only
// R15 - Chip select high masks all commands
// R16 - Command from strobes, write enable, chip select
// R17 - Reset is asynchronous both ways; here only reset_pin_n acts without a clock, rst_b acts on the next clock edge
// R18 - Masked write beats stay unwritten; here the mask is ignored while the termination strobe is enabled
// R19 - Controller tracks open rows for power states
package ca_pkg;

	localparam int ADDR_W = 16;
	localparam int BANK_W = 3;
	localparam int NUM_BANKS = 8;
	localparam int AP_BIT = 10;
	localparam int BC_BIT = 12;
	localparam int CLK_PERIOD_PS = 4000;

	// Command codes: {ras_n, cas_n, we_n}
	localparam logic [2:0] CMD_MRS = 3'h0;
	localparam logic [2:0] CMD_REF = 3'h1;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_ACT = 3'h3;
	localparam logic [2:0] CMD_WR = 3'h4;
	localparam logic [2:0] CMD_RD = 3'h5;

	typedef enum logic [3:0] {
		ST_ACTIVE = 4'h1,
		ST_PDN_PRE = 4'h2,
		ST_PDN_ACT = 4'h4,
		ST_SELF_REF = 4'h8
	} pwr_state_e;

	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic cke;
		logic termination_enable;
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] addr;
	} ca_pins_s;

	typedef struct packed {
		logic act;
		logic rd;
		logic wr;
		logic pre;
		logic pre_all;
		logic mode_register_set;
		logic refresh;
		logic auto_precharge;
		logic burst_len_eight;
		logic [BANK_W-1:0] bank;
		logic [1:0] mode_sel;
		logic [ADDR_W-1:0] row;
		logic [ADDR_W-1:0] col;
		logic [ADDR_W-1:0] opcode;
	} ca_cmd_s;

endpackage

// *** ca_input_stage.sv ***
/*
 * Command, address and clock-enable input stage of a DDR3-style DRAM.
 * Assumes clk is the true-rise/complement-fall crossing and that pins are already
 * timed to it; the controller keeps command spacing legal.
 * Two resets: rst_b acts on the next edge, reset_pin_n acts at once.
 * Mode settings arrive as steady levels from mode registers held elsewhere.
 */
`timescale 1ns/100ps
`default_nettype none
module ca_input_stage #(
	parameter bit BYTE_WIDE = 1'b1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic reset_pin_n,
	input wire ca_pkg::ca_pins_s pins,
	input wire logic otf_chop_en,
	input wire logic term_strobe_sel,
	input wire logic wr_beat_valid,
	input wire logic write_data_mask,
	output logic wr_beat_commit,
	output ca_pkg::ca_cmd_s cmd_ff,
	output logic [ca_pkg::NUM_BANKS-1:0] open_banks_ff,
	output ca_pkg::pwr_state_e pwr_ff,
	output logic internal_clk_en,
	output logic ca_buf_en,
	output logic clk_buf_en,
	output logic termination_strobe_n_en,
	output logic no_function_ball
);
	import ca_pkg::*;

	ca_cmd_s nxt_cmd;
	wire logic [NUM_BANKS-1:0] nxt_open_banks;
	pwr_state_e nxt_pwr;

	logic [2:0] code;
	logic decode_on;
	logic ap_bit;
	logic chop_bit;
	logic is_act;
	logic is_rd;
	logic is_wr;
	logic is_rw;
	logic is_pre;
	logic is_ref;

	logic hit_act;
	logic hit_close_one;
	logic hit_close_all;
	logic ref_entry;
	logic any_open;

	logic in_active;
	logic in_self_ref;
	logic mask_live;

	// Elaboration checks: the decode needs these fields to exist
	if (ADDR_W <= BC_BIT) begin : g_bad_addr_w
		$error("Address width too small for burst chop bit");
	end
	if (ADDR_W <= AP_BIT) begin : g_bad_ap_bit
		$error("Address width too small for auto precharge bit");
	end
	if (BANK_W < 2) begin : g_bad_bank_w
		$error("Bank width too small for mode register select");
	end
	if (NUM_BANKS != (1 << BANK_W)) begin : g_bad_banks
		$error("Bank count does not match bank select width");
	end

	// Command code and qualifiers, all taken from one edge
	assign code = {pins.ras_n, pins.cas_n, pins.we_n}; // R16
	// Only decode while awake; self refresh and power-down ignore commands
	assign decode_on = in_active && pins.cke && !pins.cs_n; // R15 R9
	assign ap_bit = pins.addr[AP_BIT]; // R2 R3
	assign chop_bit = pins.addr[BC_BIT]; // R5
	assign is_act = (code == CMD_ACT);
	assign is_rd = (code == CMD_RD);
	assign is_wr = (code == CMD_WR);
	assign is_rw = is_rd || is_wr;
	assign is_pre = (code == CMD_PRE);
	assign is_ref = (code == CMD_REF);

	// Row map strobes; read/write with auto precharge closes its row at once
	assign hit_act = decode_on && is_act; // R1
	assign hit_close_one = decode_on && ((is_rw && ap_bit) || (is_pre && !ap_bit)); // R2 R3
	assign hit_close_all = decode_on && is_pre && ap_bit; // R3
	assign any_open = (open_banks_ff != '0); // R10
	// Refresh code with cke low; only meaningful once every bank is idle
	assign ref_entry = !pins.cs_n && is_ref; // R10

	always_comb begin
		nxt_cmd = '0;
		if (decode_on) begin
			nxt_cmd.bank = pins.bank; // R6
			unique case (code)
				CMD_ACT: begin
					nxt_cmd.act = 1'b1;
					nxt_cmd.row = pins.addr; // R1
				end
				CMD_RD, CMD_WR: begin
					nxt_cmd.rd = is_rd;
					nxt_cmd.wr = is_wr;
					nxt_cmd.col = pins.addr; // R1
					nxt_cmd.auto_precharge = ap_bit; // R2
					// Without on-the-fly chop every burst is eight beats
					if (otf_chop_en) begin
						nxt_cmd.burst_len_eight = chop_bit; // R5
					end else begin
						nxt_cmd.burst_len_eight = 1'b1; // R5
					end
				end
				CMD_PRE: begin
					nxt_cmd.pre = 1'b1;
					nxt_cmd.pre_all = ap_bit; // R3
				end
				CMD_MRS: begin
					nxt_cmd.mode_register_set = 1'b1;
					nxt_cmd.mode_sel = pins.bank[1:0]; // R7
					nxt_cmd.opcode = pins.addr; // R4
				end
				CMD_REF: begin
					nxt_cmd.refresh = 1'b1;
				end
				// No-operation and calibration codes carry only the bank field
				default: begin
					nxt_cmd.bank = pins.bank;
				end
			endcase
		end
	end

	// One open-row bit per bank; an all-bank precharge needs no bank match
	for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
		wire logic sel;
		wire logic set_row;
		wire logic clear_row;
		assign sel = (pins.bank == BANK_W'(b)); // R6
		assign set_row = sel && hit_act; // R1
		assign clear_row = hit_close_all || (sel && hit_close_one); // R2 R3
		assign nxt_open_banks[b] = clear_row ? 1'b0
			: set_row ? 1'b1
			: open_banks_ff[b];
	end

	always_comb begin
		nxt_pwr = pwr_ff;
		unique case (pwr_ff)
			ST_ACTIVE: begin
				// Open rows decide between the two power-down flavours
				if (!pins.cke) begin // R10 R11
					if (any_open) begin
						nxt_pwr = ST_PDN_ACT;
					end else if (ref_entry) begin
						nxt_pwr = ST_SELF_REF;
					end else begin
						nxt_pwr = ST_PDN_PRE;
					end
				end
			end
			ST_PDN_PRE, ST_PDN_ACT: begin
				if (pins.cke) begin
					nxt_pwr = ST_ACTIVE; // R11
				end
			end
			ST_SELF_REF: begin
				// Exit waits for an edge; a stopped clock would need a pin latch
				if (pins.cke) begin
					nxt_pwr = ST_ACTIVE; // R11
				end
			end
		endcase
	end

	// Each state group clears on the reset pin at once, without a clock
	always_ff @(posedge clk or negedge reset_pin_n) begin // R17
		if (!reset_pin_n) begin
			pwr_ff <= ST_ACTIVE;
		end else if (!rst_b) begin
			pwr_ff <= ST_ACTIVE;
		end else begin // R8
			pwr_ff <= nxt_pwr;
		end
	end

	always_ff @(posedge clk or negedge reset_pin_n) begin // R17
		if (!reset_pin_n) begin
			open_banks_ff <= '0;
		end else if (!rst_b) begin
			open_banks_ff <= '0;
		end else begin // R8
			open_banks_ff <= nxt_open_banks;
		end
	end

	always_ff @(posedge clk or negedge reset_pin_n) begin // R17
		if (!reset_pin_n) begin
			cmd_ff <= '0;
		end else if (!rst_b) begin
			cmd_ff <= '0;
		end else begin // R8
			cmd_ff <= nxt_cmd;
		end
	end

	assign in_active = (pwr_ff == ST_ACTIVE);
	assign in_self_ref = (pwr_ff == ST_SELF_REF);
	// Gating follows the registered state, so a cke change acts one edge late
	assign internal_clk_en = in_active; // R9
	assign ca_buf_en = in_active; // R12 R13
	assign clk_buf_en = !in_self_ref; // R12 R13
	// Only the byte-wide part can lend the shared ball to the strobe
	assign termination_strobe_n_en = BYTE_WIDE && term_strobe_sel; // R14
	assign no_function_ball = !termination_strobe_n_en; // R14
	// Strobe mode takes the mask ball, so mask is ignored then
	assign mask_live = write_data_mask && !termination_strobe_n_en; // R14 R18
	assign wr_beat_commit = wr_beat_valid && !mask_live; // R18

endmodule
`default_nettype wire

// *** ca_input_stage_chk.sv ***
/* Port assertions. Assumes one clock. */
`timescale 1ns/100ps
`default_nettype none
module ca_input_stage_chk (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic reset_pin_n,
	input wire logic otf_chop_en,
	input wire ca_pkg::ca_pins_s pins,
	input wire ca_pkg::ca_cmd_s cmd_ff,
	input wire logic [7:0] open_banks_ff,
	input wire ca_pkg::pwr_state_e pwr_ff
);
	import ca_pkg::*;
	wire logic [15:0] a = pins.addr;
	wire logic [2:0] op = {pins.ras_n, pins.cas_n, pins.we_n};
	wire logic go = pins.cke && !pins.cs_n && pwr_ff == ST_ACTIVE;
	wire logic rw = go && op[2:1] == 2'h2;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b || !reset_pin_n);
	a_act_row: assert property (go && op == CMD_ACT |=>
		cmd_ff.row == $past(a) && cmd_ff.bank == $past(pins.bank)) else $error("act");
	a_auto_pre: assert property (rw |=> cmd_ff.auto_precharge == $past(a[10]))
		else $error("ap");
	a_pre_all: assert property (go && op == CMD_PRE |=>
		cmd_ff.pre_all == $past(a[10])) else $error("pre");
	a_mode_load: assert property (go && op == CMD_MRS |=>
		cmd_ff.opcode == $past(a) && cmd_ff.mode_sel == $past(pins.bank[1:0])) else $error("mrs");
	a_chop_bit: assert property (rw && otf_chop_en |=>
		cmd_ff.burst_len_eight == $past(a[12])) else $error("chop");
	a_cs_mask: assert property (pins.cs_n |=> cmd_ff == '0) else $error("cs");
	a_act_pdn: assert property (pwr_ff == ST_ACTIVE && !pins.cke && open_banks_ff != 0 |=>
		pwr_ff == ST_PDN_ACT) else $error("pdn");
	a_cke_wake: assert property (pwr_ff != ST_ACTIVE && pins.cke |=>
		pwr_ff == ST_ACTIVE) else $error("wake");
endmodule
bind ca_input_stage ca_input_stage_chk i_chk (.*);
`default_nettype wire

// *** ca_ctrl_model.sv ***
/* Controller model. Assumes one send at a time. */
`timescale 1ns/100ps
`default_nettype none
module ca_ctrl_model (
	input wire logic clk,
	output ca_pkg::ca_pins_s pins
);
	import ca_pkg::*;
	initial pins = 25'h1F00000;
	// Deselect shows inverted address, never a stale value
	task automatic send(logic [2:0] c, logic [2:0] ba, logic [15:0] a,
		logic ke = 1, logic cs = 0);
		@(posedge clk) #1 pins = {cs, c, ke, 1'b0, ba, a};
		@(posedge clk) #1 pins = {4'hF, ke, 1'b0, ~ba, ~a};
	endtask
endmodule
`default_nettype wire

// *** ca_input_stage_bench.sv ***
/* Bench for the input stage. Assumes the model drives pins. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
$display("mismatch %0t %h %h", $time, g, e); end end
module ca_input_stage_bench;
	import ca_pkg::*;
	logic clk = 0, rst_b = 0, reset_pin_n = 1, otf_chop_en = 1;
	logic wr_beat_valid = 1, write_data_mask = 1, term_strobe_sel = 0;
	logic wr_beat_commit, internal_clk_en, ca_buf_en, clk_buf_en;
	logic termination_strobe_n_en, no_function_ball;
	logic [7:0] open_banks_ff;
	ca_pins_s pins;
	ca_cmd_s cmd_ff;
	pwr_state_e pwr_ff;
	int errors = 0, checks = 0;
	always #2 clk = ~clk;
	ca_ctrl_model i_ctrl (
		.clk(clk),
		.pins(pins)
	);
	ca_input_stage i_dut (
		.clk(clk),
		.rst_b(rst_b),
		.reset_pin_n(reset_pin_n),
		.pins(pins),
		.otf_chop_en(otf_chop_en),
		.term_strobe_sel(term_strobe_sel),
		.wr_beat_valid(wr_beat_valid),
		.write_data_mask(write_data_mask),
		.wr_beat_commit(wr_beat_commit),
		.cmd_ff(cmd_ff),
		.open_banks_ff(open_banks_ff),
		.pwr_ff(pwr_ff),
		.internal_clk_en(internal_clk_en),
		.ca_buf_en(ca_buf_en),
		.clk_buf_en(clk_buf_en),
		.termination_strobe_n_en(termination_strobe_n_en),
		.no_function_ball(no_function_ball)
	);
	task automatic t_decode;
		i_ctrl.send(CMD_ACT, 3'h3, 16'h1234);
		`CHK({cmd_ff.act, cmd_ff.row, cmd_ff.bank}, 20'h891A3)
		i_ctrl.send(CMD_RD, 3'h3, 16'h0400);
		`CHK({cmd_ff.rd, cmd_ff.auto_precharge, cmd_ff.burst_len_eight}, 3'h6)
		i_ctrl.send(CMD_WR, 3'h6, 16'h1155);
		`CHK({cmd_ff.bank, cmd_ff.burst_len_eight, cmd_ff.col[9:0]}, 14'h3555)
		i_ctrl.send(CMD_PRE, 3'h5, 16'h0);
		`CHK({cmd_ff.pre_all, cmd_ff.bank}, 4'h5)
		i_ctrl.send(CMD_PRE, 3'h2, 16'h0400);
		`CHK(cmd_ff.pre_all, 1'b1)
		for (int m = 0; m < 4; m++) begin
			i_ctrl.send(CMD_MRS, m[2:0], 16'hC3 << m);
			`CHK({cmd_ff.mode_sel, cmd_ff.opcode}, {m[1:0], 16'hC3 << m})
		end
	endtask
	task automatic t_power;
		i_ctrl.send(CMD_ACT, 3'h0, 16'h0);
		i_ctrl.send(3'h7, 3'h0, 16'h0, 1'b0, 1'b1);
		`CHK({pwr_ff, ca_buf_en, clk_buf_en, internal_clk_en}, 7'h22)
		i_ctrl.send(3'h7, 3'h0, 16'h0, 1'b1, 1'b1);
		`CHK(pwr_ff, ST_ACTIVE)
		i_ctrl.send(CMD_PRE, 3'h0, 16'h0400);
		i_ctrl.send(CMD_REF, 3'h0, 16'h0, 1'b0);
		`CHK({pwr_ff, ca_buf_en, clk_buf_en}, 6'h20)
		i_ctrl.send(3'h7, 3'h0, 16'h0, 1'b1, 1'b1);
		i_ctrl.send(3'h7, 3'h0, 16'h0, 1'b0, 1'b1);
		`CHK(pwr_ff, ST_PDN_PRE)
		i_ctrl.send(3'h7, 3'h0, 16'h0, 1'b1, 1'b1);
		i_ctrl.send(CMD_ACT, 3'h7, 16'h0, 1'b1, 1'b1);
		`CHK({cmd_ff, open_banks_ff, wr_beat_commit}, '0)
	endtask
	task automatic t_strobe;
		otf_chop_en = 0;
		i_ctrl.send(CMD_RD, 3'h1, 16'h0000);
		`CHK(cmd_ff.burst_len_eight, 1'b1)
		otf_chop_en = 1;
		@(posedge clk) #1 write_data_mask = 0;
		#1 `CHK({wr_beat_commit, termination_strobe_n_en, no_function_ball}, 3'h5)
		@(posedge clk) #1 term_strobe_sel = 1;
		write_data_mask = 1;
		#1 `CHK({wr_beat_commit, termination_strobe_n_en, no_function_ball}, 3'h6)
		@(posedge clk) #1 term_strobe_sel = 0;
		wr_beat_valid = 0;
		#1 `CHK(wr_beat_commit, 1'b0)
	endtask
	task automatic t_reset_pin;
		i_ctrl.send(CMD_ACT, 3'h2, 16'h0);
		`CHK(open_banks_ff, 8'h04)
		i_ctrl.send(3'h7, 3'h0, 16'h0, 1'b0, 1'b1);
		`CHK(pwr_ff, ST_PDN_ACT)
		#1 reset_pin_n = 0;
		#1 `CHK({pwr_ff, open_banks_ff}, 12'h100)
		@(posedge clk) #1 reset_pin_n = 1;
		i_ctrl.send(3'h7, 3'h0, 16'h0, 1'b1, 1'b1);
		i_ctrl.send(CMD_MRS, 3'h1, 16'h00A5);
		`CHK({cmd_ff.mode_sel, cmd_ff.opcode}, 18'h100A5)
	endtask
	task automatic tally_and_finish;
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		#1 rst_b = 1;
		t_decode();
		t_power();
		t_strobe();
		t_reset_pin();
		tally_and_finish();
	end
endmodule
`default_nettype wire
